// file: rtl/tasr_pkg.sv
package tasr_pkg;

   // ----------------------------------------
   // values held by the block
   // ----------------------------------------
   localparam logic [15:0] TEMP_POR = 16'h0550;
   localparam int CMP_MSB = 11;
   localparam int CMP_LSB = 4;
   localparam logic [7:0] RESERVED_BYTE = 8'hFF;

   // ----------------------------------------
   // scratchpad byte positions
   // ----------------------------------------
   localparam logic [3:0] IDX_TEMP_LSB = 4'h0;
   localparam logic [3:0] IDX_TEMP_MSB = 4'h1;
   localparam logic [3:0] IDX_HIGH = 4'h2;
   localparam logic [3:0] IDX_LOW = 4'h3;

   // ----------------------------------------
   // command codes
   // ----------------------------------------
   localparam logic [7:0] CMD_SKIP_ROM = 8'hCC;
   localparam logic [7:0] CMD_READ_POWER = 8'hB4;
   localparam logic [7:0] CMD_CONVERT = 8'h44;
   localparam logic [7:0] CMD_COPY = 8'h48;
   localparam logic [7:0] CMD_ALARM_SEARCH = 8'hEC;

   typedef enum logic [1:0] {ST_IDLE, ST_SKIP, ST_PWRQ, ST_CONV} tasr_state_e;

   // signed byte compare of result bits 11..4 against both thresholds
   function automatic logic alarm_check(input logic [15:0] temp,
                                        input logic [7:0] high,
                                        input logic [7:0] low);
      logic signed [7:0] t;
      t = signed'(temp[CMP_MSB:CMP_LSB]);
      return (t <= signed'(low)) || (t > signed'(high));
   endfunction

endpackage

// file: rtl/tasr_alarm.sv
`timescale 1ns/1ps
// Function
// [RL1] power-on temperature reads plus eighty-five degrees
// [RL2] temperature is sixteen-bit sign-extended sixteenths
// [RL3] compare result with thresholds after conversion
// [RL4] threshold bit seven is the sign
// [RL5] compare uses only result bits eleven-four
// [RL6] alarm when low or above high
// [RL7] alarm re-evaluated at every conversion end
// [RL8] alarm search answered only with alarm set
// [RL9] master reconverts after changing any threshold
// [RL10] thresholds nonvolatile, scratchpad bytes two, three
// [RL11] master enables strong pullup within ten microseconds
// [RL12] master holds pullup through conversion or write
// [RL13] no bus activity while pullup enabled
// [RL14] external supply needs no pullup, bus free
// [RL15] power query slot pulled low when parasitic
// [RL16] low power answer means pullup every conversion
// [RL17] external supply: poll reads zero while busy
// [RL18] signed compare; flag unchanged by threshold writes
module tasr_alarm
   import tasr_pkg::*;
(
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_code,
   input wire logic read_slot,
   input wire logic ext_powered,
   input wire logic conv_done,
   input wire logic [15:0] conv_result,
   input wire logic spad_wr,
   input wire logic [3:0] spad_wr_addr,
   input wire logic [7:0] spad_wr_data,
   input wire logic [3:0] spad_rd_addr,
   input wire logic [7:0] nv_high,
   input wire logic [7:0] nv_low,
   output logic [15:0] temperature,
   output logic [7:0] alarm_high_threshold,
   output logic [7:0] alarm_low_threshold,
   output logic alarm_flag,
   output logic search_active,
   output logic conv_busy,
   output logic conv_start,
   output logic nv_write,
   output logic [7:0] rd_data,
   output logic dq_out,
   output logic dq_oe
);

   tasr_state_e state, next_state;
   logic [15:0] next_temperature;
   logic [7:0] next_high, next_low, next_rd_data;
   logic next_alarm_flag, next_search_active, next_conv_busy;
   logic next_conv_start, next_nv_write, next_dq_oe;
   logic conv_end;

   assign conv_end = conv_done && conv_busy;

   // ----------------------------------------
   // next-state logic
   // ----------------------------------------
   always_comb begin
      next_state = state;
      next_temperature = temperature;
      next_high = alarm_high_threshold;
      next_low = alarm_low_threshold;
      next_alarm_flag = alarm_flag;
      next_search_active = search_active;
      next_conv_busy = conv_busy;
      next_conv_start = 1'b0;
      next_nv_write = 1'b0;
      next_dq_oe = 1'b0;
      // a result only counts while a conversion was asked for
      if (conv_end) begin
         next_temperature = conv_result; // RL2
         next_alarm_flag = alarm_check(conv_result, alarm_high_threshold,
                                       alarm_low_threshold); // RL3 RL4 RL5 RL6 RL7 RL18
         next_conv_busy = 1'b0;
      end
      // threshold writes leave the flag alone until the next conversion
      if (spad_wr) begin
         case (spad_wr_addr)
            IDX_HIGH: begin
               next_high = spad_wr_data; // RL10 RL18
            end
            IDX_LOW: begin
               next_low = spad_wr_data; // RL10 RL18
            end
            default: begin
            end
         endcase
      end
      if (cmd_valid) begin
         next_state = ST_IDLE;
         next_search_active = 1'b0;
         case (cmd_code)
            CMD_SKIP_ROM: begin
               next_state = ST_SKIP;
            end
            CMD_READ_POWER: begin
               if (state == ST_SKIP) begin
                  next_state = ST_PWRQ;
               end
            end
            CMD_CONVERT: begin
               // a start in the same cycle as a late result wins
               next_state = ST_CONV;
               next_conv_busy = 1'b1;
               next_conv_start = 1'b1;
            end
            CMD_COPY: begin
               next_nv_write = 1'b1; // RL10
            end
            CMD_ALARM_SEARCH: begin
               next_search_active = alarm_flag; // RL8
            end
            default: begin
            end
         endcase
      end else if (read_slot) begin
         case (state)
            ST_PWRQ: begin
               next_dq_oe = !ext_powered; // RL15 RL14
               next_state = ST_IDLE;
            end
            ST_CONV: begin
               // parasitic parts stay silent: the bus is on the strong pullup
               next_dq_oe = ext_powered && conv_busy; // RL17 RL14
            end
            default: begin
            end
         endcase
      end
      case (spad_rd_addr)
         IDX_TEMP_LSB: begin
            next_rd_data = temperature[7:0];
         end
         IDX_TEMP_MSB: begin
            next_rd_data = temperature[15:8];
         end
         IDX_HIGH: begin
            next_rd_data = alarm_high_threshold;
         end
         IDX_LOW: begin
            next_rd_data = alarm_low_threshold;
         end
         default: begin
            next_rd_data = RESERVED_BYTE;
         end
      endcase
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         state <= ST_IDLE;
         temperature <= TEMP_POR; // RL1
         // nonvolatile copy reloaded on power-on
         alarm_high_threshold <= nv_high; // RL10
         alarm_low_threshold <= nv_low; // RL10
         alarm_flag <= 1'b0;
         search_active <= 1'b0;
         conv_busy <= 1'b0;
         conv_start <= 1'b0;
         nv_write <= 1'b0;
         rd_data <= RESERVED_BYTE;
         dq_out <= 1'b0;
         dq_oe <= 1'b0;
      end else begin
         state <= next_state;
         temperature <= next_temperature;
         alarm_high_threshold <= next_high;
         alarm_low_threshold <= next_low;
         alarm_flag <= next_alarm_flag;
         search_active <= next_search_active;
         conv_busy <= next_conv_busy;
         conv_start <= next_conv_start;
         nv_write <= next_nv_write;
         rd_data <= next_rd_data;
         dq_out <= 1'b0;
         dq_oe <= next_dq_oe;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (srst);

   por_temp_a: assert property (@(posedge clk_sys) disable iff (1'b0) // RL1
      srst |=> temperature == TEMP_POR)
      else $error("temperature not at power-on value after reset");

   temp_load_a: assert property (conv_end |=> // RL2
      temperature == $past(conv_result))
      else $error("conversion result not stored");

   alarm_eval_a: assert property (conv_end |=> // RL3 RL6
      alarm_flag == alarm_check($past(conv_result),
                                $past(alarm_high_threshold),
                                $past(alarm_low_threshold)))
      else $error("alarm flag wrong after conversion");

   alarm_hold_a: assert property (!conv_end ##1 !srst |-> // RL18
      $stable(alarm_flag))
      else $error("alarm flag changed without a conversion");

   search_resp_a: assert property (cmd_valid && cmd_code == CMD_ALARM_SEARCH |=> // RL8
      search_active == $past(alarm_flag))
      else $error("alarm search answer does not follow flag");

   thr_write_a: assert property (spad_wr && spad_wr_addr == IDX_LOW && !conv_end |=> // RL10
      alarm_low_threshold == $past(spad_wr_data) && $stable(alarm_flag))
      else $error("low threshold write lost");

   pwr_query_a: assert property (state == ST_PWRQ && read_slot && !cmd_valid |=> // RL15
      dq_oe == !$past(ext_powered) ##1 !dq_oe)
      else $error("power query slot answered wrongly");

   conv_poll_a: assert property (state == ST_CONV && read_slot && !cmd_valid |=> // RL17
      dq_oe == ($past(ext_powered) && $past(conv_busy)))
      else $error("conversion poll slot answered wrongly");

   // ----------------------------------------
   // checks on commands, slots and scratchpad reads
   // ----------------------------------------

   conv_start_a: assert property (cmd_valid && cmd_code == CMD_CONVERT |=> // RL17
      conv_start && conv_busy && state == ST_CONV)
      else $error("convert command did not start a conversion");

   copy_pulse_a: assert property (cmd_valid && cmd_code == CMD_COPY |=> // RL10
      nv_write)
      else $error("copy command did not request a store");

   search_clear_a: assert property (cmd_valid && cmd_code != CMD_ALARM_SEARCH |=> // RL8
      !search_active)
      else $error("search answer kept after another command");

   skip_refuse_a: assert property (cmd_valid && cmd_code == CMD_READ_POWER && // RL15
      state != ST_SKIP |=> state == ST_IDLE)
      else $error("power query accepted without a preceding skip");

   idle_slot_a: assert property (read_slot && !cmd_valid && state != ST_PWRQ && // RL15
      state != ST_CONV |=> !dq_oe)
      else $error("bus pulled low in a slot with nothing to answer");

   temp_rd_a: assert property (spad_rd_addr == IDX_TEMP_MSB |=> // RL2
      rd_data == $past(temperature[15:8]))
      else $error("temperature upper byte read wrongly");

   thr_rd_a: assert property (spad_rd_addr == IDX_HIGH |=> // RL10
      rd_data == $past(alarm_high_threshold))
      else $error("high threshold read wrongly");

   low_rd_a: assert property (spad_rd_addr == IDX_LOW |=> // RL10
      rd_data == $past(alarm_low_threshold))
      else $error("low threshold read wrongly");

   rsv_rd_a: assert property (spad_rd_addr > IDX_LOW |=>
      rd_data == RESERVED_BYTE)
      else $error("reserved byte did not read as all ones");

   // ----------------------------------------
   // checks on conversion results and thresholds
   // ----------------------------------------

   conv_clear_a: assert property (conv_end && !(cmd_valid && cmd_code == CMD_CONVERT) // RL7
      |=> !conv_busy)
      else $error("conversion still busy after its result");

   temp_hold_a: assert property (!conv_end |=> // RL2
      $stable(temperature))
      else $error("temperature changed without a conversion");

   high_write_a: assert property (spad_wr && spad_wr_addr == IDX_HIGH && // RL10 RL18
      !conv_end |=> alarm_high_threshold == $past(spad_wr_data) && $stable(alarm_flag))
      else $error("high threshold write lost");

   neg_high_a: assert property (conv_end && alarm_high_threshold[7] && // RL4 RL18
      !conv_result[11] |=> alarm_flag)
      else $error("positive result not above a negative high threshold");

   low_equal_a: assert property (conv_end && // RL5 RL6
      conv_result[CMP_MSB:CMP_LSB] == alarm_low_threshold |=> alarm_flag)
      else $error("result equal to low threshold raised no alarm");

   por_thr_a: assert property (@(posedge clk_sys) disable iff (1'b0) srst |=> // RL10
      alarm_high_threshold == $past(nv_high) && alarm_low_threshold == $past(nv_low))
      else $error("thresholds not reloaded from the stored copy");

   cv_alarm_c: cover property (conv_end ##1 alarm_flag);
   cv_query_c: cover property (cmd_valid && cmd_code == CMD_SKIP_ROM ##[1:2]
      cmd_valid && cmd_code == CMD_READ_POWER ##[1:4] dq_oe);
   cv_search_c: cover property (cmd_valid && cmd_code == CMD_ALARM_SEARCH ##1
      search_active);
   cv_poll_c: cover property (state == ST_CONV && read_slot && conv_busy ##1
      dq_oe);
   cv_parasite_c: cover property (conv_end && !ext_powered);

endmodule // tasr_alarm

// file: tb/tasr_conv_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// converter stand-in: answers each start after a fixed delay
// ----------------------------------------
module tasr_conv_model #(parameter int DLY = 8) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic conv_start,
   input wire logic [15:0] value,
   output logic conv_done,
   output logic [15:0] conv_result
);
   int cnt;
   always_ff @(posedge clk_sys) begin
      conv_done <= 1'b0;
      // result toggles outside done so a stale value cannot pass
      conv_result <= ~conv_result;
      if (srst) begin
         cnt <= 0;
         conv_result <= 16'h0000;
      end else if (conv_start) begin
         cnt <= DLY;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
         if (cnt == 1) begin
            conv_done <= 1'b1;
            conv_result <= value;
         end
      end
   end
endmodule // tasr_conv_model

// file: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
   import tasr_pkg::*;
   logic clk_sys, srst, cmd_valid, read_slot, ext_powered, spad_wr, conv_done;
   logic alarm_flag, search_active, conv_busy, conv_start, nv_write, dq_out, dq_oe;
   logic [7:0] cmd_code, spad_wr_data, nv_high, nv_low, rd_data;
   logic [7:0] alarm_high_threshold, alarm_low_threshold;
   logic [3:0] spad_wr_addr, spad_rd_addr;
   logic [15:0] conv_value, conv_result, temperature;
   logic strong_pullup;
   int n_fail = 0;
   int n_tests = 0;

   tasr_alarm u_tasr_alarm (.clk_sys, .srst, .cmd_valid, .cmd_code, .read_slot,
      .ext_powered, .conv_done, .conv_result, .spad_wr, .spad_wr_addr, .spad_wr_data,
      .spad_rd_addr, .nv_high, .nv_low, .temperature, .alarm_high_threshold,
      .alarm_low_threshold, .alarm_flag, .search_active, .conv_busy, .conv_start,
      .nv_write, .rd_data, .dq_out, .dq_oe);
   tasr_conv_model u_tasr_conv_model (.clk_sys, .srst, .conv_start,
      .value(conv_value), .conv_done, .conv_result);

   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic send(input logic [7:0] c);
      check(strong_pullup, 1'b0);
      @(posedge clk_sys);
      cmd_valid <= 1'b1;
      cmd_code <= c;
      @(posedge clk_sys);
      cmd_valid <= 1'b0;
      #1;
   endtask

   task automatic slot();
      check(strong_pullup, 1'b0);
      @(posedge clk_sys);
      read_slot <= 1'b1;
      @(posedge clk_sys);
      read_slot <= 1'b0;
      #1;
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      spad_wr <= 1'b1;
      spad_wr_addr <= a;
      spad_wr_data <= d;
      @(posedge clk_sys);
      spad_wr <= 1'b0;
      #1;
   endtask

   // one conversion with external supply, polled, then an alarm search
   task automatic convert(input logic [15:0] v, input logic exp);
      conv_value <= v;
      send(CMD_CONVERT);
      check(conv_start, 1'b1);
      slot();
      check(dq_oe, 1'b1);
      for (int i = 0; i < 40 && conv_busy === 1'b1; i++)
         @(posedge clk_sys);
      #1;
      check(conv_busy, 1'b0);
      check(temperature, v);
      check(alarm_flag, exp);
      slot();
      check(dq_oe, 1'b0);
      send(CMD_ALARM_SEARCH);
      check(search_active, exp);
   endtask

   // scratchpad byte read: the byte stands one cycle after its position
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk_sys);
      spad_rd_addr <= a;
      @(posedge clk_sys);
      #1;
      check(rd_data, exp);
   endtask

   // parasite supply: strong pullup over the whole conversion, bus kept quiet
   task automatic convert_parasite(input logic [15:0] v, input logic exp);
      @(posedge clk_sys);
      ext_powered <= 1'b0;
      conv_value <= v;
      send(CMD_CONVERT);
      strong_pullup <= 1'b1;
      for (int i = 0; i < 40 && conv_busy === 1'b1; i++)
         @(posedge clk_sys);
      strong_pullup <= 1'b0;
      #1;
      check(conv_busy, 1'b0);
      check(temperature, v);
      check(alarm_flag, exp);
      slot();
      check(dq_oe, 1'b0);
      @(posedge clk_sys);
      ext_powered <= 1'b1;
   endtask

   // reset in mid-run: a scratchpad-only edit is lost, the stored copy returns
   task automatic mid_reset();
      wr(IDX_HIGH, 8'h33);
      @(posedge clk_sys);
      srst <= 1'b1;
      nv_high <= 8'hF0;
      nv_low <= 8'h00;
      repeat (2) @(posedge clk_sys);
      srst <= 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
      check(temperature, 16'h0550);
      check(alarm_high_threshold, 8'hF0);
      check(alarm_low_threshold, 8'h00);
      check(alarm_flag, 1'b0);
      check(search_active, 1'b0);
      rd(IDX_TEMP_MSB, 8'h05);
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      srst = 1'b1;
      cmd_valid = 1'b0;
      cmd_code = 8'h00;
      read_slot = 1'b0;
      ext_powered = 1'b1;
      spad_wr = 1'b0;
      spad_wr_addr = 4'h0;
      spad_wr_data = 8'h00;
      spad_rd_addr = IDX_TEMP_MSB;
      nv_high = 8'h7D;
      nv_low = 8'hC9;
      conv_value = 16'h0000;
      strong_pullup = 1'b0;
      repeat (10) @(posedge clk_sys);
      srst <= 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
      check(temperature, 16'h0550);
      check(rd_data, 8'h05);
      check(alarm_high_threshold, 8'h7D);
      check(alarm_low_threshold, 8'hC9);
      for (int p = 0; p < 2; p++) begin
         ext_powered <= p[0];
         send(CMD_SKIP_ROM);
         send(CMD_READ_POWER);
         slot();
         check(dq_oe, !p[0]);
         check(dq_out, 1'b0);
      end
      slot();
      check(dq_oe, 1'b0);
      // a power query without the skip before it is ignored
      ext_powered <= 1'b0;
      send(CMD_READ_POWER);
      slot();
      check(dq_oe, 1'b0);
      ext_powered <= 1'b1;
      wr(IDX_HIGH, 8'h19);
      wr(IDX_LOW, 8'h0A);
      check(alarm_high_threshold, 8'h19);
      rd(IDX_HIGH, 8'h19);
      rd(IDX_LOW, 8'h0A);
      rd(4'h5, 8'hFF);
      convert(16'hFE6F, 1'b1);
      convert(16'h0191, 1'b0);
      convert(16'hF0F8, 1'b0);
      convert(16'h01A0, 1'b1);
      convert(16'h00A0, 1'b1);
      convert(16'h00B0, 1'b0);
      wr(IDX_LOW, 8'h20);
      check(alarm_flag, 1'b0);
      convert(16'h00B0, 1'b1);
      wr(IDX_HIGH, 8'hF0);
      wr(IDX_LOW, 8'h00);
      convert(16'h0191, 1'b1);
      rd(IDX_TEMP_LSB, 8'h91);
      send(CMD_COPY);
      check(nv_write, 1'b1);
      convert_parasite(16'hFC90, 1'b1);
      mid_reset();
      finish_test();
   end

   // the sequence needs well under a thousand cycles; 20000 leaves margin
   initial begin
      #1000000;
      n_fail++;
      finish_test();
   end
endmodule // testbench
